// file: src/spi_port_pkg.sv
// Constants, register map and state types for the SPI port.
// Assumes a 200 MHz core clock and a 32-bit AHB-Lite register bus.
package spi_port_pkg;
    // ************************************************************
    // Clock and timing.
    // ************************************************************
    localparam int CLK_HZ = 32'h0bebc200;
    localparam int TIMEOUT_MS = 32'h0000_1388;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 32'h0000_03e8);
    localparam int CODE_N = 32'h8;
    localparam logic [2:0] CODE_MAX = 3'h7;
    // ************************************************************
    // Data path sizes.
    // ************************************************************
    localparam int WORD_W = 32'h10;
    localparam int FIFO_DEPTH = 32'h8;
    localparam logic [4:0] LAST8 = 5'h0f;
    localparam logic [4:0] LAST16 = 5'h1f;
    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_BAUD = 5'h04;
    localparam logic [4:0] A_POLY = 5'h08;
    localparam logic [4:0] A_TXD = 5'h0c;
    localparam logic [4:0] A_RXD = 5'h10;
    localparam logic [4:0] A_STAT = 5'h14;
    localparam logic [4:0] A_CRC = 5'h18;
    // ************************************************************
    // Control fields, status fields and reset values.
    // ************************************************************
    localparam int CTRL_W = 32'hc;
    localparam int C_EN = 32'h0;
    localparam int C_MST = 32'h1;
    localparam int C_CPOL = 32'h2;
    localparam int C_CPHA = 32'h3;
    localparam int C_WIDE = 32'h4;
    localparam int C_LSB = 32'h5;
    localparam int C_CRC = 32'h6;
    localparam int C_KEEP = 32'h7;
    localparam int C_FORCE = 32'h8;
    localparam int C_PSC_LO = 32'h9;
    localparam int C_PSC_HI = 32'hb;
    localparam int S_BUSY = 32'h0;
    localparam int S_EMPTY = 32'h1;
    localparam int S_FULL = 32'h2;
    localparam int S_RXV = 32'h3;
    localparam int S_OVR = 32'h4;
    localparam int S_TMO = 32'h5;
    localparam int S_CODE_LO = 32'h8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h086;
    localparam logic [31:0] DEF_BAUD = 32'h0005_01bd;
    localparam logic [15:0] POLY_RST = 16'h0007;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic {ENG_IDLE, ENG_RUN} eng_t;
endpackage

// file: src/spi_fifo_if.sv
// Handshake bundle between the SPI port and its transmit word queue.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface spi_fifo_if #(parameter int W = 16);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// file: src/spi_word_fifo.sv
// Word queue with valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/100ps
module spi_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    spi_fifo_if.store q
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_st_t;
    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // ************************************************************
    // Handshakes: full and empty come straight from the count.
    // ************************************************************
    assign q.in_ready = st_ff.cnt != (AW+1)'(DEPTH);
    assign q.out_valid = st_ff.cnt != '0;
    assign q.out_data = mem[st_ff.rd];
    assign push = q.in_valid && q.in_ready;
    assign pop = q.out_valid && q.out_ready;

    // Pointer and count update.
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage needs no reset; nothing is read before it is written.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_ff.wr] <= q.in_data;
        end
    end
endmodule

// file: src/spi_port.sv
// SPI serial port, master or slave, with an AHB-Lite register slave.
// Assumes one 200 MHz clock, a single AHB master and an external peer;
// slave select is handled outside this block.
//
// Notes on behaviour
// - The serial clock rests at the polarity level whenever no word moves.
// - Phase 0 samples on the first edge of each bit, phase 1 on the second.
// - A word is 8 or 16 bits by configuration and its bits move back to back.
// - Bits move most or least significant first by the bit-order setting.
// - As master the serial clock is the core clock divided by 2 to 256 in powers of two.
// - The port is master driving the clock or slave taking it; the rate only affects master.
// - An explicit divider is used directly and beats any requested rate.
// - An optional CRC runs over the data with a set polynomial, and is idle when off.
// - In full duplex one word is captured for each word sent, on the same edges.
// - The port neither drives nor senses slave select.
// - Defaults are idle high, first-edge sampling, 8 bits, MSB first, CRC off, a 328125 Hz rate that runs the clock at 781250 Hz (divide by 256).
// - A word not finished within the timeout, 5000 ms by default, is dropped and flagged.
// - Disabling stops all transfers until the port is configured again.
// - Reopening without new settings keeps the last configuration.
`timescale 1ns/100ps
module spi_port
    import spi_port_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe
);
    typedef struct packed {
        logic [1:0] sck_sy;
        logic [1:0] mosi_sy;
        logic [1:0] miso_sy;
        logic sck_prev;
        logic dph_wr;
        logic dph_tx;
        logic [4:0] dph_a;
        logic [31:0] rdata;
        logic [CTRL_W-1:0] ctrl;
        logic [31:0] baud;
        logic [15:0] poly;
        eng_t eng;
        logic [2:0] code;
        logic [7:0] hcnt;
        logic sck;
        logic [4:0] edge_n;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [15:0] rxd;
        logic rxv;
        logic ovr;
        logic tmo_err;
        logic [31:0] tmo;
        logic [15:0] crc;
    } st_t;

    st_t st_ff;
    st_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic rst_sync_b;
    logic en, mst, cpol, cpha, wide, lsb, crc_on, keep, force_psc;
    logic [2:0] psc;
    logic [7:0] half_m1;
    logic [4:0] last_n;
    logic take;
    logic tx_bit;

    spi_fifo_if #(.W(WORD_W)) txq ();

    spi_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_txq (
        .clk(core_clk),
        .rst_b(rst_sync_b),
        .q(txq)
    );

    // ************************************************************
    // Helpers.
    // ************************************************************
    // Smallest divider code whose clock does not exceed the rate; the largest code when none does.
    function automatic logic [2:0] pick_code(input logic [31:0] rate);
        logic [2:0] c;
        logic hit;
        c = CODE_MAX;
        hit = 1'b0;
        for (int k = 0; k < CODE_N; k++) begin
            if (!hit && ((32'(CLK_HZ) >> (k + 1)) <= rate)) begin
                c = 3'(k);
                hit = 1'b1;
            end
        end
        return c;
    endfunction

    // Bit currently presented on the data line.
    function automatic logic bit_out(input logic [15:0] w, input logic wd, input logic lf);
        return lf ? w[0] : (wd ? w[15] : w[7]);
    endfunction

    // ************************************************************
    // Reset release and configuration decode.
    // ************************************************************
    // Reset asserts at once but leaves only after two clean edges.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_sync_ff[1];

    // Settings live in one register and survive disable and re-enable.
    assign en = st_ff.ctrl[C_EN];
    assign mst = st_ff.ctrl[C_MST];
    assign cpol = st_ff.ctrl[C_CPOL];
    assign cpha = st_ff.ctrl[C_CPHA];
    assign wide = st_ff.ctrl[C_WIDE];
    assign lsb = st_ff.ctrl[C_LSB];
    assign crc_on = st_ff.ctrl[C_CRC];
    assign keep = st_ff.ctrl[C_KEEP];
    assign force_psc = st_ff.ctrl[C_FORCE];
    assign psc = st_ff.ctrl[C_PSC_HI:C_PSC_LO];
    assign half_m1 = (8'h01 << st_ff.code) - 8'h01;
    assign last_n = wide ? LAST16 : LAST8;

    // ************************************************************
    // Bus and pin outputs.
    // ************************************************************
    // A data write to the queue waits while the queue is full.
    assign take = hsel && htrans[1] && hready;
    assign hreadyout = !st_ff.dph_tx || txq.in_ready;
    assign hresp = HRESP_OKAY;
    assign hrdata = st_ff.rdata;
    assign txq.in_valid = st_ff.dph_tx;
    assign txq.in_data = hwdata[WORD_W-1:0];
    assign txq.out_ready = (st_ff.eng == ENG_IDLE) && en;

    // Only clock and data lines exist; slave select is left outside.
    assign tx_bit = bit_out(st_ff.tx, wide, lsb);
    assign sck_out = st_ff.sck;
    assign sck_oe = en && mst;
    assign mosi_out = tx_bit;
    assign mosi_oe = en && mst;
    assign miso_out = tx_bit;
    assign miso_oe = en && !mst;

    // ************************************************************
    // Next-state logic: bus side first, engine second, so that
    // engine events win over software clears in the same cycle.
    // ************************************************************
    always_comb begin
        logic edge_ev;
        logic samp;
        logic adv;
        logic din;
        logic fb;
        logic [15:0] rxn;
        logic [15:0] rfin;
        logic [31:0] stat;
        edge_ev = 1'b0;
        samp = 1'b0;
        adv = 1'b0;
        fb = 1'b0;
        din = 1'b0;
        rxn = 16'h0;
        rfin = 16'h0;
        nxt_st = st_ff;
        // Pins pass two flops; only the second stage is used.
        nxt_st.sck_sy = {st_ff.sck_sy[0], sck_in};
        nxt_st.mosi_sy = {st_ff.mosi_sy[0], mosi_in};
        nxt_st.miso_sy = {st_ff.miso_sy[0], miso_in};
        nxt_st.sck_prev = st_ff.sck_sy[1];
        din = mst ? st_ff.miso_sy[1] : st_ff.mosi_sy[1];
        stat = 32'h0;
        stat[S_BUSY] = st_ff.eng == ENG_RUN;
        stat[S_EMPTY] = !txq.out_valid;
        stat[S_FULL] = !txq.in_ready;
        stat[S_RXV] = st_ff.rxv;
        stat[S_OVR] = st_ff.ovr;
        stat[S_TMO] = st_ff.tmo_err;
        stat[S_CODE_LO +: 3] = st_ff.code;
        // Data phase of a write completes when the slave is ready.
        if (st_ff.dph_wr && hreadyout) begin
            case (st_ff.dph_a)
                A_CTRL: begin
                    nxt_st.ctrl = hwdata[CTRL_W-1:0];
                    nxt_st.crc = 16'h0;
                end
                A_BAUD: nxt_st.baud = hwdata;
                A_POLY: begin
                    nxt_st.poly = hwdata[15:0];
                    nxt_st.crc = 16'h0;
                end
                A_STAT: begin
                    nxt_st.ovr = st_ff.ovr && !hwdata[S_OVR];
                    nxt_st.tmo_err = st_ff.tmo_err && !hwdata[S_TMO];
                end
                default: nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        // Address phase: read data is prepared here, one stage early.
        nxt_st.dph_wr = take && hwrite;
        nxt_st.dph_tx = take && hwrite && (haddr[4:0] == A_TXD);
        nxt_st.dph_a = haddr[4:0];
        nxt_st.rdata = 32'h0;
        if (take && !hwrite) begin
            case (haddr[4:0])
                A_CTRL: nxt_st.rdata = 32'(st_ff.ctrl);
                A_BAUD: nxt_st.rdata = st_ff.baud;
                A_POLY: nxt_st.rdata = 32'(st_ff.poly);
                A_RXD: begin
                    nxt_st.rdata = 32'(st_ff.rxd);
                    nxt_st.rxv = 1'b0;
                end
                A_STAT: nxt_st.rdata = stat;
                A_CRC: nxt_st.rdata = 32'(st_ff.crc);
                default: nxt_st.rdata = 32'h0;
            endcase
        end
        rxn = lsb ? {din, st_ff.rx[15:1]} : {st_ff.rx[14:0], din};
        unique case (st_ff.eng)
            ENG_IDLE: begin
                nxt_st.sck = cpol;
                nxt_st.hcnt = 8'h0;
                nxt_st.edge_n = 5'h0;
                nxt_st.tmo = 32'h0;
                // Divider is frozen for the word; explicit code wins.
                nxt_st.code = force_psc ? psc : pick_code(st_ff.baud);
                if (txq.out_valid && txq.out_ready) begin
                    nxt_st.eng = ENG_RUN;
                    nxt_st.tx = txq.out_data;
                    nxt_st.rx = 16'h0;
                end
            end
            ENG_RUN: begin
                nxt_st.tmo = st_ff.tmo + 32'h1;
                // Master toggles every half period; slave follows the pin.
                if (mst) begin
                    if (st_ff.hcnt == half_m1) begin
                        nxt_st.hcnt = 8'h0;
                        nxt_st.sck = !st_ff.sck;
                        edge_ev = 1'b1;
                    end else begin
                        nxt_st.hcnt = st_ff.hcnt + 8'h01;
                    end
                end else begin
                    edge_ev = st_ff.sck_sy[1] != st_ff.sck_prev;
                end
                // Even edges lead, odd edges trail.
                samp = edge_ev && (st_ff.edge_n[0] == cpha);
                adv = edge_ev && (st_ff.edge_n[0] != cpha) && (st_ff.edge_n != 5'h0);
                if (samp) begin
                    nxt_st.rx = rxn;
                    if (crc_on) begin
                        fb = st_ff.crc[15] ^ din;
                        nxt_st.crc = {st_ff.crc[14:0], 1'b0} ^ (fb ? st_ff.poly : 16'h0);
                    end
                end
                if (adv) begin
                    nxt_st.tx = lsb ? {1'b0, st_ff.tx[15:1]} : {st_ff.tx[14:0], 1'b0};
                end
                if (edge_ev) begin
                    nxt_st.edge_n = st_ff.edge_n + 5'h01;
                end
                rfin = samp ? rxn : st_ff.rx;
                if (edge_ev && (st_ff.edge_n == last_n)) begin
                    nxt_st.eng = ENG_IDLE;
                    // Send-only use simply leaves the receive slot alone.
                    if (keep) begin
                        nxt_st.rxd = wide ? rfin :
                            {8'h0, (lsb ? rfin[15:8] : rfin[7:0])};
                        nxt_st.ovr = nxt_st.ovr || nxt_st.rxv;
                        nxt_st.rxv = 1'b1;
                    end
                end
                // A stuck peer must not hang the port for ever.
                if (st_ff.tmo == 32'(TIMEOUT_CYCLES - 1)) begin
                    nxt_st.eng = ENG_IDLE;
                    nxt_st.tmo_err = 1'b1;
                    nxt_st.sck = cpol;
                end
                if (!en) begin
                    nxt_st.eng = ENG_IDLE;
                    nxt_st.sck = cpol;
                end
            end
        endcase
    end

    // State register with documented defaults.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RST;
            st_ff.baud <= DEF_BAUD;
            st_ff.poly <= POLY_RST;
            st_ff.sck <= CTRL_RST[C_CPOL];
            st_ff.code <= CODE_MAX;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    logic sck_d_ff;
    logic [7:0] gap_ff;
    logic [5:0] tog_ff;

    // Clock edge counters watched by the checks below.
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sck_d_ff <= 1'b0;
            gap_ff <= 8'h0;
            tog_ff <= 6'h0;
        end else begin
            sck_d_ff <= st_ff.sck;
            gap_ff <= (st_ff.sck != sck_d_ff) ? 8'h0 : gap_ff + 8'h01;
            if (st_ff.eng == ENG_IDLE) begin
                tog_ff <= 6'h0;
            end else if (st_ff.sck != sck_d_ff) begin
                tog_ff <= tog_ff + 6'h01;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    sequence s_word_start;
        st_ff.eng == ENG_IDLE && txq.out_valid && txq.out_ready;
    endsequence
    sequence s_word_end;
        st_ff.eng == ENG_RUN ##1 st_ff.eng == ENG_IDLE;
    endsequence

    a_idle_clk_level: assert property (
        en && mst && st_ff.eng == ENG_IDLE && $stable(st_ff.ctrl) |-> sck_out == cpol)
        else $error("idle serial clock not at polarity level");
    a_sample_edge: assert property (
        mst && st_ff.eng == ENG_RUN && $past(st_ff.eng) == ENG_RUN && $changed(st_ff.rx)
        |-> (st_ff.sck != cpol) == !cpha)
        else $error("sample taken on the wrong clock edge");
    a_word_edges: assert property (
        mst && en ##0 s_word_end |-> tog_ff == {1'b0, last_n})
        else $error("word edge count does not match width");
    a_half_period: assert property (
        mst && st_ff.eng == ENG_RUN && st_ff.sck != sck_d_ff && tog_ff != 6'h0
        |-> gap_ff == half_m1)
        else $error("serial clock half period wrong");
    a_slave_no_clock: assert property (
        !mst |-> !sck_oe && !mosi_oe)
        else $error("slave drives clock or data out");
    a_code_forced: assert property (
        st_ff.eng == ENG_IDLE && force_psc |=> st_ff.code == $past(psc))
        else $error("explicit divider not used");
    a_code_picked: assert property (
        st_ff.eng == ENG_IDLE && !force_psc |=>
        ((32'(CLK_HZ) >> (4'(st_ff.code) + 4'h1)) <= $past(st_ff.baud)
            || st_ff.code == CODE_MAX)
        && (st_ff.code == 3'h0 || (32'(CLK_HZ) >> st_ff.code) > $past(st_ff.baud)))
        else $error("divider not the smallest fitting one");
    a_crc_quiet: assert property (
        !crc_on && !(st_ff.dph_wr && hreadyout) |=> $stable(st_ff.crc))
        else $error("crc moved while disabled");
    a_rx_capture: assert property (
        en && keep && st_ff.eng == ENG_RUN && nxt_st.eng == ENG_IDLE
        && st_ff.tmo != 32'(TIMEOUT_CYCLES - 1) |=> st_ff.rxv)
        else $error("finished word not captured");
    a_timeout_cut: assert property (
        st_ff.eng == ENG_RUN && st_ff.tmo == 32'(TIMEOUT_CYCLES - 1)
        |=> st_ff.eng == ENG_IDLE && st_ff.tmo_err)
        else $error("timeout did not abandon word");
    a_disable_stop: assert property (
        !en && !(st_ff.dph_wr && st_ff.dph_a == A_CTRL)
        |=> st_ff.eng == ENG_IDLE && !sck_oe && !mosi_oe && !miso_oe)
        else $error("port active while disabled");
    a_pop_idle: assert property (
        s_word_start |=> st_ff.eng == ENG_RUN && st_ff.tx == $past(txq.out_data))
        else $error("word not loaded on start");
endmodule

// file: test/spi_peer.sv
// Behavioural SPI peer that answers the port while the port is master.
// Assumes the bench pulses start before each word and holds the mode inputs.
`timescale 1ns/100ps
module spi_peer (
    input wire logic sck,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic wide,
    input wire logic lsb,
    input wire logic start,
    input wire logic mosi,
    input wire logic [15:0] tx,
    output logic miso,
    output logic [15:0] rx
);
    int n = 0;
    int bits = 0;
    // Position of the k-th bit on the wire for the chosen order.
    function automatic int idx(int k);
        return lsb ? k : bits - 1 - k;
    endfunction
    // A new word starts with its first bit already on the line.
    always @(posedge start) begin
        n = 0;
        bits = wide ? 16 : 8;
        rx = '0;
        miso = tx[idx(0)];
    end
    // Sample on one edge, shift on the other; once the word ends the line flips.
    always @(sck) begin
        if (n < bits) begin
            if ((sck !== cpol) ^ cpha) begin
                rx[idx(n)] = mosi;
                if (cpha) n++;
                if (n >= bits) miso = ~miso;
            end else begin
                if (!cpha) n++;
                miso = (n < bits) ? tx[idx(n)] : ~miso;
            end
        end
    end
endmodule

// file: test/tb.sv
// Self-checking bench for the SPI port over its AHB-Lite registers.
// Assumes the peer model on the serial side and a short slave timeout.
`timescale 1ns/100ps
module tb;
    import spi_port_pkg::*;
    logic core_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, go = 0;
    logic cpol = 1, cpha = 0, wide = 0, lsb = 0, miso;
    logic ssck = 0, smosi = 0;
    logic [7:0] sb = 8'h96, sw = 8'h3c;
    logic hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, tx;
    logic [1:0] htrans = 0;
    logic [15:0] ptx = 0, prx;
    int fail_count = 0, tests_run = 0;
    realtime t0 = 0, gap = 0;
    spi_port #(.TIMEOUT_CYCLES(2000)) uut (.core_clk(core_clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sck_in(ssck), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(smosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso),
        .miso_out(miso_out), .miso_oe(miso_oe));
    spi_peer peer (.sck(sck_out), .cpol(cpol), .cpha(cpha), .wide(wide), .lsb(lsb),
        .start(go), .mosi(mosi_out), .tx(ptx), .miso(miso), .rx(prx));
    // The clock runs at 200 MHz.
    initial forever #2.5 core_clk = ~core_clk;
    // Shortest spacing of serial clock edges gives the divider in use.
    always @(sck_out) begin
        if (sck_oe === 1'b1 && $realtime - t0 < gap) gap = $realtime - t0;
        t0 = $realtime;
    end
    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d, wrong %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // One single AHB transfer; outputs are read before this edge's updates land.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        hsel <= 1'b1;
        haddr <= {27'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 500);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 500);
        r = hrdata;
        if (n >= 500) begin
            chk(32'h0, 32'h1, "bus timeout");
            report_and_stop();
        end
    endtask
    // Poll status until the engine is idle and the queue is empty.
    task automatic wait_idle();
        int n = 0;
        do begin bus(1'b0, A_STAT, 0); n++; end while (!(r[S_BUSY] === 1'b0 &&
            r[S_EMPTY] === 1'b1) && n < 2000);
        if (n >= 2000) begin chk(32'h0, 32'h1, "idle timeout"); report_and_stop(); end
    endtask
    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        bus(1'b0, A_CTRL, 0); chk(r, 32'h86, "ctrl reset");
        bus(1'b0, A_BAUD, 0); chk(r, DEF_BAUD, "rate reset");
        bus(1'b0, A_STAT, 0); chk({29'h0, r[10:8]}, 32'h7, "divider");
        bus(1'b0, 5'h1c, 0); chk(r, 0, "unmapped");
        chk({31'h0, hresp}, 32'h0, "okay response");
        $display("test reset done");
        // Every mix of polarity, phase, width and order, divider forced to 16.
        for (int i = 0; i < 16; i++) begin
            {lsb, wide, cpha, cpol} <= i[3:0];
            tx = 32'ha5c3 + i;
            ptx <= ~tx[15:0];
            bus(1'b1, A_CTRL, 32'h783 | (i << 2));
            // The idle clock moves to the new level first; arming the peer
            // before that would count the level change as a bit edge.
            repeat (2) @(posedge core_clk);
            gap = 1.0e6;
            go <= 1'b1;
            bus(1'b1, A_TXD, tx);
            go <= 1'b0;
            wait_idle();
            if (!i[2]) tx = tx & 32'hff;
            bus(1'b0, A_RXD, 0); chk(r, ~tx & (i[2] ? 32'hffff : 32'hff), "rx word");
            chk({16'h0, prx}, tx, "peer word");
            chk({31'h0, sck_out}, i[0], "idle level");
            chk(gap == 40.0, 1, "sck rate");
            bus(1'b0, A_CRC, 0); chk(r, 0, "crc off");
        end
        $display("test modes done");
        // Words wait while disabled; a disable in mid-word stops the clock.
        cpol <= 1'b0;
        bus(1'b1, A_CTRL, 32'h782);
        for (int k = 0; k < 8; k++) bus(1'b1, A_TXD, k);
        bus(1'b0, A_STAT, 0); chk({29'h0, r[2:0]}, 32'h4, "full idle");
        bus(1'b1, A_CTRL, 32'h783);
        wait_idle();
        bus(1'b1, A_TXD, 1);
        bus(1'b1, A_CTRL, 32'h782);
        // The engine drops the word one cycle after the disable lands.
        @(posedge core_clk);
        bus(1'b0, A_STAT, 0); chk(r[S_BUSY], 0, "abort");
        chk({31'h0, sck_out}, 0, "abort level");
        bus(1'b0, A_CTRL, 0); chk(r, 32'h782, "kept");
        $display("test queue done");
        // A slave word with no clock from the peer is dropped and flagged.
        bus(1'b1, A_CTRL, 32'h081);
        bus(1'b1, A_TXD, 5);
        repeat (2100) @(posedge core_clk);
        bus(1'b0, A_STAT, 0); chk({r[S_TMO], r[S_BUSY]}, 2, "timeout");
        $display("test timeout done");
        // A slave word clocked by the bench: mode 0, MSB first, 8 bits.
        bus(1'b1, A_TXD, {24'h0, sw});
        for (int k = 7; k >= 0; k--) begin
            smosi <= sb[k];
            repeat (8) @(posedge core_clk);
            chk({31'h0, miso_out}, {31'h0, sw[k]}, "slave bit");
            ssck <= 1'b1;
            repeat (8) @(posedge core_clk);
            ssck <= 1'b0;
        end
        chk({30'h0, miso_oe, mosi_oe}, 32'h2, "slave pins");
        wait_idle();
        bus(1'b0, A_RXD, 0); chk(r, {24'h0, sb}, "slave word");
        $display("test slave done");
        report_and_stop();
    end
endmodule
